// >>> rtl/misc_cfg_pkg.sv
// Package for the miscellaneous supply, clock and shutdown register bank.
// Assumes a single 100 MHz control clock and a plain register port.
package misc_cfg_pkg;

    // Register offsets
    localparam logic [7:0] OFS_SUPPLY_STS   = 8'h03;
    localparam logic [7:0] OFS_CLKERR_BCAST = 8'h04;
    localparam logic [7:0] OFS_PRECHG_SHDN  = 8'h05;
    localparam logic [7:0] OFS_SUPPLY_SEL   = 8'h06;
    localparam logic [7:0] OFS_CLK_LOSS     = 8'h07;
    localparam logic [7:0] OFS_IRQ_STS      = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h09;

    // Field positions
    localparam int ANA_FLAG_BIT   = 7;
    localparam int IO_FLAG_BIT    = 6;
    localparam int IGNORE_ERR_BIT = 6;
    localparam int BCAST_BIT      = 1;
    localparam int PRECHG_LSB     = 6;
    localparam int SHDN_LSB       = 4;
    localparam int HOLD_LSB       = 2;
    localparam int CLK_LOSS_BIT   = 4;
    localparam int ANA_SEL_BIT    = 1;
    localparam int IO_SEL_BIT     = 0;
    localparam int IRQ_PRECHG     = 0;
    localparam int IRQ_HOLD_TOUT  = 1;
    localparam int IRQ_CLK_LOSS   = 2;
    localparam int IRQ_OVERRIDE   = 3;

    // Reset values and writable bits
    localparam logic [7:0] RST_CLKERR_BCAST = 8'h00;
    localparam logic [7:0] RST_PRECHG_SHDN  = 8'h15;
    localparam logic [7:0] RST_CLK_LOSS     = 8'h00;
    localparam logic [7:0] RST_SUPPLY_SEL   = 8'h00;
    localparam logic [3:0] RST_IRQ          = 4'h0;
    localparam logic [7:0] WM_CLKERR_BCAST  = 8'h42;
    localparam logic [7:0] WM_PRECHG_SHDN   = 8'hFC;
    localparam logic [7:0] WM_CLK_LOSS      = 8'h10;
    localparam logic [7:0] WM_SUPPLY_SEL    = 8'h03;

    // Timing
    localparam int CLK_MHZ        = 100;
    localparam int CNT_W          = 23;
    localparam int PRECHG_T_US [4] = '{2500, 12500, 25000, 50000};
    localparam int HOLD_T_US   [4] = '{30000, 25000, 10000, 5000};
    localparam int CLK_LOSS_T_US  = 2000;

    typedef enum logic [3:0] {
        SD_ON   = 4'h1,
        SD_HOLD = 4'h2,
        SD_WAIT = 4'h4,
        SD_OFF  = 4'h8
    } shdn_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic analog_3v3_det;
        logic io_3v3_det;
        logic io_supply_present;
        logic clean_shutdown_done;
        logic sel_clock_present;
        logic clock_error_raw;
        logic precharge_start;
    } sense_t;

    typedef struct packed {
        logic [7:0]       clkerr_bcast;
        logic [7:0]       prechg_shdn;
        logic [7:0]       clk_loss;
        logic [7:0]       supply_sel;
        logic [3:0]       irq_sts;
        logic [3:0]       irq_mask;
        logic             ana_flag;
        logic             io_flag;
        logic [7:0]       rd_data;
        logic             io_prev;
        logic             prechg_active;
        logic [CNT_W-1:0] prechg_cnt;
        shdn_state_t      sd_state;
        logic [CNT_W-1:0] hold_cnt;
        logic             loss_armed;
        logic [CNT_W-1:0] loss_cnt;
        logic             hard_reset;
    } state_t;

endpackage

// >>> rtl/misc_cfg_regs.sv
// Miscellaneous supply override, clock error, broadcast, precharge,
// shutdown keep-alive and clock-loss reset registers with their timers.
// Assumes all inputs synchronous to clk; reads answer one cycle later.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps

module misc_cfg_regs
    import misc_cfg_pkg::*;
#(
    parameter int PRECHG_CYC [4] = '{PRECHG_T_US[0] * CLK_MHZ, PRECHG_T_US[1] * CLK_MHZ,
                                     PRECHG_T_US[2] * CLK_MHZ, PRECHG_T_US[3] * CLK_MHZ},
    parameter int HOLD_CYC   [4] = '{HOLD_T_US[0] * CLK_MHZ, HOLD_T_US[1] * CLK_MHZ,
                                     HOLD_T_US[2] * CLK_MHZ, HOLD_T_US[3] * CLK_MHZ},
    parameter int LOSS_CYC       = CLK_LOSS_T_US * CLK_MHZ
) (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Register port
    input  wire reg_req_t   req,
    output logic [7:0]      rd_data,
    // Sensed conditions
    input  wire sense_t     sense,
    input  wire logic [1:0] pin_addr_lsb,
    // Controls to the rest of the device
    output logic            analog_supply_select,
    output logic            io_supply_select,
    output logic            clock_error,
    output logic [1:0]      target_addr_lsb,
    output logic            broadcast_addressing_enable,
    output logic            precharge_active,
    output logic            core_regulator_on,
    output logic            hard_reset,
    // Interrupt
    output logic            irq
);

    state_t q;
    state_t d;

    localparam state_t RST_STATE = '{
        clkerr_bcast:  RST_CLKERR_BCAST,
        prechg_shdn:   RST_PRECHG_SHDN,
        clk_loss:      RST_CLK_LOSS,
        supply_sel:    RST_SUPPLY_SEL,
        irq_sts:       RST_IRQ,
        irq_mask:      RST_IRQ,
        sd_state:      SD_ON,
        io_prev:       1'b1,
        default:       '0
    };

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [CNT_W-1:0] cyc_m1(input int n);
        cyc_m1 = CNT_W'((n > 1) ? n - 1 : 0);
    endfunction

    logic [1:0] prechg_code;
    logic [1:0] shdn_code;
    logic [1:0] hold_code;
    logic       io_removed;
    logic       io_returned;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    assign prechg_code = q.prechg_shdn[PRECHG_LSB +: 2];
    assign shdn_code   = q.prechg_shdn[SHDN_LSB +: 2];
    assign hold_code   = q.prechg_shdn[HOLD_LSB +: 2];
    assign io_removed  = q.io_prev & ~sense.io_supply_present;
    assign io_returned = ~q.io_prev & sense.io_supply_present;

    always_comb begin
        d       = q;
        irq_set = '0;
        irq_clr = '0;
        d.hard_reset = 1'b0;

        // Register writes; reserved bits are masked off
        if (req.wr) begin
            if (hit(req.addr, OFS_CLKERR_BCAST)) begin
                d.clkerr_bcast = req.wdata & WM_CLKERR_BCAST;
            end
            if (hit(req.addr, OFS_PRECHG_SHDN)) begin
                d.prechg_shdn = req.wdata & WM_PRECHG_SHDN;
            end
            if (hit(req.addr, OFS_CLK_LOSS)) begin
                d.clk_loss = req.wdata & WM_CLK_LOSS;
            end
            if (hit(req.addr, OFS_SUPPLY_SEL)) begin
                d.supply_sel = req.wdata & WM_SUPPLY_SEL;
            end
            if (hit(req.addr, OFS_IRQ_MASK)) begin
                d.irq_mask = req.wdata[3:0];
            end
            if (hit(req.addr, OFS_IRQ_STS)) begin
                irq_clr = req.wdata[3:0];
            end
        end

        // Read data stand in the following cycle only
        d.rd_data = '0;
        if (req.rd) begin
            if (hit(req.addr, OFS_SUPPLY_STS)) begin
                d.rd_data = {q.ana_flag, q.io_flag, 6'h00};
            end
            if (hit(req.addr, OFS_CLKERR_BCAST)) begin
                d.rd_data = q.clkerr_bcast;
            end
            if (hit(req.addr, OFS_PRECHG_SHDN)) begin
                d.rd_data = q.prechg_shdn;
            end
            if (hit(req.addr, OFS_CLK_LOSS)) begin
                d.rd_data = q.clk_loss;
            end
            if (hit(req.addr, OFS_SUPPLY_SEL)) begin
                d.rd_data = q.supply_sel;
            end
            if (hit(req.addr, OFS_IRQ_STS)) begin
                d.rd_data = {4'h0, q.irq_sts};
            end
            if (hit(req.addr, OFS_IRQ_MASK)) begin
                d.rd_data = {4'h0, q.irq_mask};
            end
        end

        // Supply override flags follow the sense inputs
        d.ana_flag = sense.analog_3v3_det;
        d.io_flag  = sense.io_3v3_det;
        if ((sense.analog_3v3_det & ~q.ana_flag) | (sense.io_3v3_det & ~q.io_flag)) begin
            irq_set[IRQ_OVERRIDE] = 1'b1;
        end

        // Input capacitor quick-charge timer
        if (sense.precharge_start) begin
            d.prechg_active = 1'b1;
            d.prechg_cnt    = cyc_m1(PRECHG_CYC[prechg_code]);
        end else if (q.prechg_active) begin
            if (q.prechg_cnt == '0) begin
                d.prechg_active       = 1'b0;
                irq_set[IRQ_PRECHG]   = 1'b1;
            end else begin
                d.prechg_cnt = q.prechg_cnt - CNT_W'(1);
            end
        end

        // Core regulator keep-alive after I/O supply removal
        d.io_prev = sense.io_supply_present;
        unique case (q.sd_state)
            SD_ON: begin
                if (io_removed) begin
                    unique case (shdn_code)
                        2'h0: d.sd_state = SD_OFF;
                        2'h1: begin
                            d.sd_state = SD_HOLD;
                            d.hold_cnt = cyc_m1(HOLD_CYC[hold_code]);
                        end
                        default: d.sd_state = SD_WAIT;
                    endcase
                end
            end
            SD_HOLD: begin
                if (io_returned) begin
                    d.sd_state = SD_ON;
                end else if (sense.clean_shutdown_done) begin
                    d.sd_state = SD_OFF;
                end else if (q.hold_cnt == '0) begin
                    d.sd_state             = SD_OFF;
                    irq_set[IRQ_HOLD_TOUT] = 1'b1;
                end else begin
                    d.hold_cnt = q.hold_cnt - CNT_W'(1);
                end
            end
            SD_WAIT: begin
                if (io_returned) begin
                    d.sd_state = SD_ON;
                end else if (sense.clean_shutdown_done) begin
                    d.sd_state = SD_OFF;
                end
            end
            SD_OFF: begin
                if (sense.io_supply_present) begin
                    d.sd_state = SD_ON;
                end
            end
            default: d.sd_state = SD_OFF;
        endcase

        // Selected clock absence watchdog
        if (!q.clk_loss[CLK_LOSS_BIT] || sense.sel_clock_present) begin
            d.loss_armed = 1'b1;
            d.loss_cnt   = cyc_m1(LOSS_CYC);
        end else if (q.loss_armed) begin
            if (q.loss_cnt == '0) begin
                d.loss_armed          = 1'b0;
                d.hard_reset          = 1'b1;
                irq_set[IRQ_CLK_LOSS] = 1'b1;
            end else begin
                d.loss_cnt = q.loss_cnt - CNT_W'(1);
            end
        end

        // Sticky interrupt status, set wins over clear
        for (int i = 0; i < 4; i++) begin
            d.irq_sts[i] = (q.irq_sts[i] & ~irq_clr[i]) | irq_set[i];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= RST_STATE;
        end else if (ce) begin
            q <= d;
        end
    end

    assign rd_data              = q.rd_data;
    assign analog_supply_select = q.supply_sel[ANA_SEL_BIT] & ~q.ana_flag;
    assign io_supply_select     = q.supply_sel[IO_SEL_BIT] & ~q.io_flag;
    assign clock_error          = sense.clock_error_raw & ~q.clkerr_bcast[IGNORE_ERR_BIT];
    assign broadcast_addressing_enable = q.clkerr_bcast[BCAST_BIT];
    assign target_addr_lsb      = q.clkerr_bcast[BCAST_BIT] ? 2'h0 : pin_addr_lsb;
    assign precharge_active     = q.prechg_active;
    assign core_regulator_on    = (q.sd_state != SD_OFF);
    assign hard_reset           = q.hard_reset;
    assign irq                  = |(q.irq_sts & q.irq_mask);

endmodule

// >>> dv/misc_cfg_regs_props.sv
// Checker for the misc supply, clock and shutdown register bank.
// Assumes it is bound to misc_cfg_regs and sees only that module's ports.
`timescale 1ns/100ps
module misc_cfg_regs_props
    import misc_cfg_pkg::*;
#(
    parameter int LOSS_CYC = 12
) (
    // Clock, reset, enable
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       ce,
    // Register port and sense inputs
    input wire reg_req_t   req,
    input wire logic [7:0] rd_data,
    input wire sense_t     sense,
    input wire logic [1:0] pin_addr_lsb,
    // Outputs
    input wire logic       analog_supply_select,
    input wire logic       io_supply_select,
    input wire logic       clock_error,
    input wire logic [1:0] target_addr_lsb,
    input wire logic       broadcast_addressing_enable,
    input wire logic       precharge_active,
    input wire logic       core_regulator_on,
    input wire logic       hard_reset,
    input wire logic       irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Edges seen with the selected clock absent since it last ran
    int absent_q;
    always_ff @(posedge clk) begin
        if (!rst_n) absent_q <= 0;
        else if (ce) absent_q <= sense.sel_clock_present ? 0 : absent_q + 1;
    end

    sequence s_wr(a);
        req.wr && ce && req.addr == a;
    endsequence
    sequence s_rd(a);
        req.rd && ce && req.addr == a;
    endsequence

    a_read_idle: assert property ($past(ce) && !$past(req.rd) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    a_status_read: assert property (s_rd(OFS_SUPPLY_STS) |=> rd_data ==
        {$past(sense.analog_3v3_det, 2), $past(sense.io_3v3_det, 2), 6'h00})
        else $error("supply status read wrong");
    a_bcast_write: assert property (s_wr(OFS_CLKERR_BCAST) |=>
        broadcast_addressing_enable == $past(req.wdata[BCAST_BIT]))
        else $error("broadcast bit not taken");
    a_clkerr_write: assert property (s_wr(OFS_CLKERR_BCAST) |=>
        clock_error == (sense.clock_error_raw && !$past(req.wdata[IGNORE_ERR_BIT])))
        else $error("clock error gating wrong");
    a_target_addr: assert property (target_addr_lsb ==
        (broadcast_addressing_enable ? 2'h0 : pin_addr_lsb))
        else $error("target address bits wrong");
    a_ana_override: assert property (analog_supply_select |->
        !$past(sense.analog_3v3_det))
        else $error("analog select not forced low");
    a_io_override: assert property (io_supply_select |-> !$past(sense.io_3v3_det))
        else $error("io select not forced low");
    a_prechg_start: assert property (sense.precharge_start && ce |=> precharge_active)
        else $error("precharge did not start");
    a_loss_count: assert property (hard_reset |-> absent_q == LOSS_CYC)
        else $error("hard reset at wrong absence count");
    a_reset_pulse: assert property (hard_reset |=> !hard_reset)
        else $error("hard reset longer than one cycle");
    a_irq_masked: assert property (s_wr(OFS_IRQ_MASK) ##0 req.wdata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high while fully masked");
    a_reg_back: assert property ($rose(sense.io_supply_present) |=> core_regulator_on)
        else $error("regulator not back on with supply");
endmodule

bind misc_cfg_regs misc_cfg_regs_props #(.LOSS_CYC(LOSS_CYC)) props (.clk, .rst_n, .ce, .req,
    .rd_data, .sense, .pin_addr_lsb, .analog_supply_select, .io_supply_select, .clock_error,
    .target_addr_lsb, .broadcast_addressing_enable, .precharge_active, .core_regulator_on,
    .hard_reset, .irq);

// >>> dv/misc_cfg_regs_test.sv
// Self-checking bench for the misc supply, clock and shutdown register bank.
// Assumes the checker file is compiled alongside; timers use short counts.
`timescale 1ns/100ps
module misc_supply_clock_config_regs_test
    import misc_cfg_pkg::*;
;
    localparam int PC [4] = '{5, 9, 13, 17};
    localparam int HC [4] = '{7, 11, 15, 19};
    localparam int LOSS   = 12;

    logic       clk, rst_n, ce;
    reg_req_t   req;
    sense_t     sense;
    logic [1:0] pin_addr_lsb, target_addr_lsb;
    logic [7:0] rd_data;
    logic       analog_supply_select, io_supply_select, clock_error;
    logic       broadcast_addressing_enable, precharge_active, core_regulator_on;
    logic       hard_reset, irq;
    int         n_errors = 0, checks_done = 0, pulses = 0;

    misc_cfg_regs #(.PRECHG_CYC(PC), .HOLD_CYC(HC), .LOSS_CYC(LOSS)) DUT (.clk, .rst_n, .ce,
        .req, .rd_data, .sense, .pin_addr_lsb, .analog_supply_select, .io_supply_select,
        .clock_error, .target_addr_lsb, .broadcast_addressing_enable, .precharge_active,
        .core_regulator_on, .hard_reset, .irq);

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (hard_reset === 1'b1) pulses <= pulses + 1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1 chk(rd_data, exp);
    endtask
    // Counts the cycles a timer output stays high after its trigger edge
    task measure(input int which, input int exp);
        int n;
        n = 0;
        #1;
        while (n < 100 && (which != 0 ? core_regulator_on : precharge_active) === 1'b1) begin
            n++;
            @(posedge clk) #1;
        end
        chk(n, exp);
    endtask
    task drop;
        @(posedge clk) sense.io_supply_present <= 1'b0;
        @(posedge clk);
    endtask
    task restore;
        @(posedge clk) sense.io_supply_present <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task t_regs;
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h15);
        rd(8'h07, 8'h00);
        rd(8'h0F, 8'h00);
        wr(8'h04, 8'h42);
        wr(8'h05, 8'hFC);
        wr(8'h07, 8'h10);
        wr(8'h03, 8'hC0);
        rd(8'h04, 8'h42);
        rd(8'h05, 8'hFC);
        rd(8'h07, 8'h10);
        rd(8'h03, 8'h00);
        chk(target_addr_lsb, 2'h0);
        chk(broadcast_addressing_enable, 1'b1);
        chk(clock_error, 1'b0);
        wr(8'h04, 8'h00);
        #1 chk(clock_error, 1'b1);
        chk(target_addr_lsb, 2'h3);
        chk(broadcast_addressing_enable, 1'b0);
        @(posedge clk) pin_addr_lsb <= 2'h1;
        @(posedge clk) #1 chk(target_addr_lsb, 2'h1);
        @(posedge clk) pin_addr_lsb <= 2'h3;
        wr(8'h07, 8'h00);
        // A write while the clock enable is low must be lost
        @(posedge clk) ce <= 1'b0;
        wr(8'h04, 8'h02);
        @(posedge clk) ce <= 1'b1;
        rd(8'h04, 8'h00);
        $display("register test done");
    endtask

    task t_supply;
        wr(8'h06, 8'h03);
        #1 chk({analog_supply_select, io_supply_select}, 2'h3);
        @(posedge clk) sense.analog_3v3_det <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({analog_supply_select, io_supply_select}, 2'h1);
        rd(8'h03, 8'h80);
        @(posedge clk) sense.io_3v3_det <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(io_supply_select, 1'b0);
        rd(8'h03, 8'hC0);
        chk(irq, 1'b0);
        wr(8'h09, 8'h08);
        #1 chk(irq, 1'b1);
        wr(8'h09, 8'h00);
        #1 chk(irq, 1'b0);
        wr(8'h09, 8'h08);
        wr(8'h08, 8'h08);
        #1 chk(irq, 1'b0);
        @(posedge clk) sense <= sense_t'(7'h16);
        repeat (2) @(posedge clk);
        #1 chk({analog_supply_select, io_supply_select}, 2'h3);
        rd(8'h03, 8'h00);
        $display("supply test done");
    endtask

    task t_prechg;
        for (int c = 0; c < 4; c++) begin
            wr(8'h05, {c[1:0], 6'h14});
            @(posedge clk) sense.precharge_start <= 1'b1;
            @(posedge clk) sense.precharge_start <= 1'b0;
            measure(0, PC[c]);
        end
        rd(8'h08, 8'h01);
        wr(8'h08, 8'h01);
        $display("precharge test done");
    endtask

    task t_shdn;
        wr(8'h05, 8'h00);
        drop;
        measure(1, 0);
        restore;
        for (int h = 0; h < 4; h++) begin
            wr(8'h05, {4'h1, h[1:0], 2'h0});
            drop;
            measure(1, HC[h]);
            restore;
        end
        rd(8'h08, 8'h02);
        wr(8'h08, 8'h02);
        // Clean shutdown inside the hold time ends it early without a timeout
        wr(8'h05, 8'h14);
        drop;
        @(posedge clk) sense.clean_shutdown_done <= 1'b1;
        @(posedge clk) sense.clean_shutdown_done <= 1'b0;
        @(posedge clk) #1 chk(core_regulator_on, 1'b0);
        restore;
        rd(8'h08, 8'h00);
        wr(8'h05, 8'h20);
        drop;
        repeat (30) @(posedge clk);
        #1 chk(core_regulator_on, 1'b1);
        @(posedge clk) sense.clean_shutdown_done <= 1'b1;
        @(posedge clk) sense.clean_shutdown_done <= 1'b0;
        @(posedge clk) #1 chk(core_regulator_on, 1'b0);
        restore;
        $display("shutdown test done");
    endtask

    task t_loss;
        int n;
        @(posedge clk) sense.sel_clock_present <= 1'b0;
        repeat (LOSS + 4) @(posedge clk);
        @(posedge clk) sense.sel_clock_present <= 1'b1;
        #1 chk(pulses, 0);
        wr(8'h07, 8'h10);
        @(posedge clk) sense.sel_clock_present <= 1'b0;
        @(posedge clk) #1;
        n = 1;
        while (hard_reset !== 1'b1 && n < 100) begin
            @(posedge clk) #1;
            n++;
        end
        chk(n, LOSS);
        repeat (2 * LOSS) @(posedge clk);
        #1 chk(pulses, 1);
        rd(8'h08, 8'h04);
        @(posedge clk) sense.sel_clock_present <= 1'b1;
        wr(8'h07, 8'h00);
        $display("clock loss test done");
    endtask

    task results;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #100us;
        n_errors++;
        results();
    end

    initial begin
        ce = 1'b1;
        rst_n = 1'b0;
        req = '0;
        pin_addr_lsb = 2'h3;
        sense = sense_t'(7'h16);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_supply();
        t_prechg();
        t_shdn();
        t_loss();
        results();
    end
endmodule
